// ---- bench/adc_node_model.sv ----
// converter model: sample code per probed node, noisy while idle
`timescale 1ns/1ps
module adc_node_model (
  // clock
  input  wire logic       ref_clk,
  // probe controls from the block
  input  wire logic       probe_convert_on,
  input  wire logic [3:0] probe_node_select,
  // sample code to the block
  output logic [7:0]      adc_code
);
  logic [7:0] idle_q = 8'h5A;
  // toggles every cycle between 5A and A5, and A5 reads like the node 5 sample
  always_ff @(posedge ref_clk) begin
    idle_q <= idle_q ^ 8'hFF;
  end
  // one code per node: A in the upper nibble, the node select in the lower nibble
  assign adc_code = probe_convert_on ? {4'hA, probe_node_select} : idle_q;
endmodule

// ---- bench/audio_led_sync_and_led_test_bench.sv ----
// testbench: register, fun-light and led test checks for the control block
`timescale 1ns/1ps
module audio_led_sync_and_led_test_bench;
  import funlight_pkg::*;
  // ********************************
  // signals
  // ********************************
  localparam int PER = 16; // short period keeps the run brief
  logic       ref_clk      = 1'b0;
  logic       rst          = 1'b1;
  logic       reg_wr       = 1'b0;
  logic       reg_rd       = 1'b0;
  logic [6:0] reg_addr     = 7'h00;
  logic [7:0] reg_wdata    = 8'h00;
  logic [7:0] channel_byte = 8'h00;
  logic [7:0] reg_rdata, adc_code, fun_light_code;
  logic [5:0] channel_duty;
  logic [1:0] channel_pulse_level, refresh_code;
  logic [2:0] gain_code;
  logic [3:0] threshold_code, probe_node_select;
  logic       dc_removal_corner, auto_gain_on, sync_on, threshold_on;
  logic       fun_light_output, fun_light_manual, probe_convert_on;
  logic       probe_node_valid, result_valid, soft_reset_pulse;
  int         num_errors = 0;
  int         n_checks   = 0;
  always #25 ref_clk = ~ref_clk;
  // ********************************
  // block and converter model
  // ********************************
  funlight_ctrl #(.PERIOD(PER)) DUT (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .adc_code(adc_code), .channel_byte(channel_byte), .channel_duty(channel_duty),
    .channel_pulse_level(channel_pulse_level), .gain_code(gain_code),
    .dc_removal_corner(dc_removal_corner), .auto_gain_on(auto_gain_on), .sync_on(sync_on),
    .refresh_code(refresh_code), .threshold_code(threshold_code),
    .threshold_on(threshold_on), .fun_light_output(fun_light_output),
    .fun_light_code(fun_light_code), .fun_light_manual(fun_light_manual),
    .probe_node_select(probe_node_select), .probe_convert_on(probe_convert_on),
    .probe_node_valid(probe_node_valid), .result_valid(result_valid),
    .soft_reset_pulse(soft_reset_pulse));
  adc_node_model conv (.ref_clk(ref_clk), .probe_convert_on(probe_convert_on),
    .probe_node_select(probe_node_select), .adc_code(adc_code));
  // ********************************
  // shared tasks
  // ********************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // write taken at the edge with the strobe high, outputs looked at mid-cycle
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(negedge ref_clk);
    chk(reg_rdata, exp, what);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic reset_values();
    rd_chk(OFS_FUN_LIGHT_CURRENT, 8'h00, "current after reset");
    rd_chk(OFS_AUDIO_SYNC_CTRL, 8'h00, "audio after reset");
    rd_chk(OFS_LED_TEST_CTRL, 8'h00, "test after reset");
    rd_chk(7'h20, 8'h00, "unmapped read");
    chk({7'h0, probe_node_valid}, 8'h01, "node valid after reset");
  endtask
  task automatic audio_fields();
    logic [7:0] d;
    for (int g = 0; g < 8; g++) begin
      d = {g[2:0], g[0], g[1], 1'b0, g[1:0]};
      wr(OFS_AUDIO_SYNC_CTRL, d);
      chk({gain_code, dc_removal_corner, auto_gain_on, sync_on, refresh_code}, d, "audio");
      rd_chk(OFS_AUDIO_SYNC_CTRL, d, "audio readback");
    end
    wr(OFS_AUDIO_THRESHOLD, 8'hF7);
    chk({threshold_on, 3'h0, threshold_code}, 8'h87, "threshold");
    rd_chk(OFS_AUDIO_THRESHOLD, 8'h07, "threshold readback");
    wr(OFS_AUDIO_THRESHOLD, 8'h00);
    chk({threshold_on, 3'h0, threshold_code}, 8'h00, "threshold off");
  endtask
  // manual writes refused while sync is on, old code returns afterwards
  task automatic fun_light_modes();
    wr(OFS_FUN_LIGHT_CURRENT, 8'h80);
    chk({fun_light_output, fun_light_manual, 6'h0}, 8'hC0, "manual on");
    chk(fun_light_code, 8'h80, "manual code");
    wr(OFS_AUDIO_SYNC_CTRL, 8'h04);
    chk({fun_light_output, fun_light_manual, sync_on, 5'h0}, 8'hA0, "sync on");
    chk(fun_light_code, 8'h00, "code under sync");
    wr(OFS_FUN_LIGHT_CURRENT, 8'h33);
    wr(OFS_AUDIO_SYNC_CTRL, 8'h00);
    rd_chk(OFS_FUN_LIGHT_CURRENT, 8'h80, "write under sync");
    chk(fun_light_code, 8'h80, "manual code back");
    wr(OFS_FUN_LIGHT_CURRENT, 8'h00);
    chk({fun_light_output, fun_light_manual, 6'h0}, 8'h00, "driver off");
  endtask
  task automatic channel_split();
    logic [7:0] v [4] = '{8'h3F, 8'h7F, 8'hBF, 8'hFF};
    foreach (v[i]) begin
      @(posedge ref_clk);
      channel_byte <= v[i];
      @(negedge ref_clk);
      chk({channel_pulse_level, channel_duty}, v[i], "channel split");
    end
  endtask
  task automatic led_test_run();
    int n;
    // start-up wait, scaled far down to keep the run short
    repeat (4) @(negedge ref_clk);
    wr(OFS_LED_TEST_CTRL, 8'h1C);
    chk({3'h0, probe_convert_on, probe_node_select}, 8'h1C, "test fields");
    repeat (PER - 4) @(negedge ref_clk);
    chk({7'h0, result_valid}, 8'h00, "result too early");
    n = 0;
    while (result_valid !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    chk({7'h0, result_valid}, 8'h01, "first result");
    rd_chk(OFS_CONVERTER_RESULT, 8'hAC, "fun-light result");
    wr(OFS_LED_TEST_CTRL, 8'h13);
    repeat (2 * PER + 4) @(negedge ref_clk);
    rd_chk(OFS_CONVERTER_RESULT, 8'hA3, "repeated result");
    wr(OFS_CONVERTER_RESULT, 8'h55);
    rd_chk(OFS_CONVERTER_RESULT, 8'hA3, "read-only result");
    wr(OFS_LED_TEST_CTRL, 8'h1D);
    chk({6'h0, probe_node_valid, result_valid}, 8'h00, "unused node");
    wr(OFS_LED_TEST_CTRL, 8'hFF);
    rd_chk(OFS_LED_TEST_CTRL, 8'h1F, "test readback");
    wr(OFS_LED_TEST_CTRL, 8'h00);
    chk({3'h0, probe_convert_on, probe_node_select}, 8'h00, "test stopped");
  endtask
  task automatic soft_reset();
    wr(OFS_AUDIO_SYNC_CTRL, 8'hFF);
    wr(OFS_SOFT_RESET, 8'h5A);
    chk({7'h0, soft_reset_pulse}, 8'h01, "reset pulse");
    @(negedge ref_clk);
    chk({7'h0, soft_reset_pulse}, 8'h00, "reset pulse ends");
    rd_chk(OFS_AUDIO_SYNC_CTRL, 8'h00, "cleared by reset");
  endtask
  // ********************************
  // main sequence and watchdog
  // ********************************
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    reset_values();
    audio_fields();
    fun_light_modes();
    channel_split();
    led_test_run();
    soft_reset();
    complete_run();
  end
  // whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end
endmodule

// ---- rtl/fun_light_output_conv_if.sv ----
// interface: conversion request and result between control and sequencer
`timescale 1ns/1ps
interface funlight_conv_if;
  logic       convert_on;
  logic [3:0] node;
  logic       sample;
  logic       result_valid;
  modport ctrl (output convert_on, output node, input sample, input result_valid);
  modport seq  (input convert_on, input node, output sample, output result_valid);
endinterface

// ---- rtl/fun_light_output_conv_seq.sv ----
// module: 128 us conversion sequencer for the led test converter
`timescale 1ns/1ps
module funlight_conv_seq
  import funlight_pkg::*;
#(
  parameter int PERIOD = CONV_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control side
  funlight_conv_if.seq cif
);
  // ********************************
  // sequencer
  // ********************************
  conv_state_t      state_q;
  logic [15:0]      cnt_q;
  logic             last;
  assign last = (cnt_q == 16'(PERIOD - 1));

  // counter restarts on every enable so the first result lands one full period later
  always_ff @(posedge ref_clk) begin
    if (rst || !cif.convert_on) begin
      state_q <= ST_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_WAIT;
          cnt_q   <= '0;
        end
        ST_WAIT: begin
          cnt_q <= last ? '0 : cnt_q + 16'd1;
          if (last) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          cnt_q <= last ? '0 : cnt_q + 16'd1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // sample pulse once per period while enabled
  assign cif.sample       = (state_q != ST_IDLE) && (state_q != 3'b000) && last;
  assign cif.result_valid = (state_q == ST_DONE);

  // no sample may follow an enable within the first stretch of the period
  property p_first_at_period;
    @(posedge ref_clk) disable iff (rst)
    $rose(cif.convert_on) |-> !cif.sample [*8];
  endproperty
  a_first_at_period: assert property (p_first_at_period)
    else $error("sample came too early after enable");
  c_sample: cover property (@(posedge ref_clk) disable iff (rst) cif.sample);
endmodule

// ---- rtl/fun_light_output_ctrl.sv ----
// module: register file for audio sync, fun-light current and led test
`timescale 1ns/1ps
//
// Summary of operation
// - manual fun-light brightness writes have no effect while audio sync is on
// - audio control bits 7..5 hold gain code, 0 to -46 dB
// - audio control bit 4 selects dc removal corner 80 or 510 Hz
// - audio control bit 3 enables agc, otherwise gain code applies
// - audio control bit 2 enables audio synchronisation
// - audio control bits 1..0 select refresh rate, fastest to 3.8 Hz
// - threshold register bits 3..0, zero disables threshold
// - 8-bit fun-light current register, ignored while audio sync is on
// - driver active when sync on or current code nonzero
// - manual current scales linearly, 15 mA over 255 steps
// - test register node select picks rgb pin, fun-light or boost
// - setting test enable starts conversions, first result after 128 us
// - conversions repeat every 128 us while enable stays set
// - latest result readable from converter result register
// - one result step equals 27.345 mV at the pin
// - rgb channel byte holds 6-bit duty and 2-bit pulse level
module funlight_ctrl
  import funlight_pkg::*;
#(
  parameter int PERIOD = CONV_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // register port from serial interface decoder
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [6:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // converter sample in
  input  wire logic [7:0] adc_code,
  // rgb channel byte to split
  input  wire logic [7:0] channel_byte,
  output logic [5:0]      channel_duty,
  output logic [1:0]      channel_pulse_level,
  // audio path controls
  output logic [2:0]      gain_code,
  output logic            dc_removal_corner,
  output logic            auto_gain_on,
  output logic            sync_on,
  output logic [1:0]      refresh_code,
  output logic [3:0]      threshold_code,
  output logic            threshold_on,
  // fun-light driver
  output logic            fun_light_output,
  output logic [7:0]      fun_light_code,
  output logic            fun_light_manual,
  // led test mux
  output logic [3:0]      probe_node_select,
  output logic            probe_convert_on,
  output logic            probe_node_valid,
  output logic            result_valid,
  // device reset request from soft reset register
  output logic            soft_reset_pulse
);
  // ********************************
  // decode helpers
  // ********************************
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ofs);
    return reg_wr && (a == ofs);
  endfunction

  // ********************************
  // registers
  // ********************************
  logic [7:0] current_q;
  logic [7:0] audio_q;
  logic [7:0] thresh_q;
  logic [4:0] test_q;
  logic [7:0] result_q;
  logic       soft_rst_q;
  logic       clr;
  assign clr = rst || soft_rst_q;

  funlight_conv_if cif ();
  assign cif.convert_on = test_q[CONVERT_ON_BIT];
  assign cif.node = test_q[NODE_MSB:0];

  // soft reset: any write to the trigger register clears the whole block next cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= hit(reg_addr, OFS_SOFT_RESET);
    end
  end

  // manual current code; writes dropped while sync is on
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      current_q <= RST_BYTE;
    end else if (hit(reg_addr, OFS_FUN_LIGHT_CURRENT) && !audio_q[SYNC_BIT]) begin
      current_q <= reg_wdata;
    end
  end

  // audio control register
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      audio_q <= RST_BYTE;
    end else if (hit(reg_addr, OFS_AUDIO_SYNC_CTRL)) begin
      audio_q <= reg_wdata;
    end
  end

  // threshold register, upper nibble reserved
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      thresh_q <= RST_BYTE;
    end else if (hit(reg_addr, OFS_AUDIO_THRESHOLD)) begin
      thresh_q <= {4'h0, reg_wdata[THRESH_MSB:0]};
    end
  end

  // led test control, write of zero stops conversions
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      test_q <= '0;
    end else if (hit(reg_addr, OFS_LED_TEST_CTRL)) begin
      test_q <= reg_wdata[CONVERT_ON_BIT:0];
    end
  end

  // result captured on each sequencer sample pulse
  always_ff @(posedge ref_clk) begin
    if (clr) begin
      result_q <= RST_BYTE;
    end else if (cif.sample) begin
      result_q <= adc_code;
    end
  end

  // ********************************
  // sequencer
  // ********************************
  funlight_conv_seq #(
    .PERIOD (PERIOD)
  ) u_seq (
    .ref_clk (ref_clk),
    .rst     (clr),
    .cif     (cif)
  );

  // ********************************
  // read mux
  // ********************************
  // unmapped and write-only offsets read zero
  always_comb begin
    reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_FUN_LIGHT_CURRENT: reg_rdata = current_q;
        OFS_AUDIO_SYNC_CTRL:   reg_rdata = audio_q;
        OFS_AUDIO_THRESHOLD:   reg_rdata = thresh_q;
        OFS_LED_TEST_CTRL:     reg_rdata = {3'b000, test_q};
        OFS_CONVERTER_RESULT:  reg_rdata = result_q;
        default:               reg_rdata = 8'h00;
      endcase
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign gain_code         = audio_q[GAIN_MSB:GAIN_LSB];
  assign dc_removal_corner = audio_q[DC_CORNER_BIT];
  assign auto_gain_on      = audio_q[AGC_BIT];
  assign sync_on           = audio_q[SYNC_BIT];
  assign refresh_code      = audio_q[SPEED_MSB:0];
  assign threshold_code    = thresh_q[THRESH_MSB:0];
  assign threshold_on      = (thresh_q[THRESH_MSB:0] != 4'h0);
  // code passes to the linear current dac, forced to zero while sync is on, 15 mA / 255 per step
  assign fun_light_manual  = !sync_on && (current_q != RST_BYTE);
  assign fun_light_code    = sync_on ? RST_BYTE : current_q;
  assign fun_light_output  = sync_on || (current_q != RST_BYTE);
  assign probe_node_select = test_q[NODE_MSB:0];
  assign probe_convert_on  = test_q[CONVERT_ON_BIT];
  // codes 1101 and 1110 float the adc input
  assign probe_node_valid  = (probe_node_select <= NODE_FUN_LIGHT) ||
                             (probe_node_select == NODE_BOOST);
  // result lsb is 27.345 mV, scaling left to software
  assign result_valid      = cif.result_valid && probe_node_valid;
  assign soft_reset_pulse  = soft_rst_q;
  assign channel_duty        = channel_byte[DUTY_MSB:0];
  assign channel_pulse_level = channel_byte[7:PULSE_LVL_LSB];

  // ********************************
  // assertions
  // ********************************
  // write decode spelled out: a function body would read the strobe unsampled
  property p_sync_blocks_write;
    @(posedge ref_clk) disable iff (clr)
    (reg_wr && reg_addr == OFS_FUN_LIGHT_CURRENT && sync_on) |=> $stable(current_q);
  endproperty
  a_sync_blocks_write: assert property (p_sync_blocks_write)
    else $error("current changed during sync");
  property p_driver_on;
    @(posedge ref_clk) disable iff (clr)
    fun_light_output == (sync_on || (current_q != 8'h00));
  endproperty
  a_driver_on: assert property (p_driver_on)
    else $error("driver enable wrong");
  property p_zero_stops;
    @(posedge ref_clk) disable iff (clr)
    (reg_wr && reg_addr == OFS_LED_TEST_CTRL && reg_wdata == 8'h00) |=>
      !probe_convert_on ##1 !cif.sample;
  endproperty
  a_zero_stops: assert property (p_zero_stops)
    else $error("conversions kept running");
  property p_result_update;
    @(posedge ref_clk) disable iff (clr)
    cif.sample |=> (result_q == $past(adc_code));
  endproperty
  a_result_update: assert property (p_result_update)
    else $error("result not captured");
  property p_soft_reset;
    @(posedge ref_clk) disable iff (rst)
    (reg_wr && reg_addr == OFS_SOFT_RESET) |-> ##2 (test_q == 5'd0 && audio_q == 8'h00);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset missed");
  property p_unused_node;
    @(posedge ref_clk) disable iff (clr)
    (probe_node_select == 4'hD || probe_node_select == 4'hE) |-> !result_valid;
  endproperty
  a_unused_node: assert property (p_unused_node)
    else $error("valid on unused node");
  property p_code_zero_sync;
    @(posedge ref_clk) disable iff (clr) sync_on |-> fun_light_code == 8'h00;
  endproperty
  a_code_zero_sync: assert property (p_code_zero_sync)
    else $error("manual code leaked during sync");
  property p_thresh;
    @(posedge ref_clk) disable iff (clr) threshold_on |-> thresh_q[3:0] != 4'h0;
  endproperty
  a_thresh: assert property (p_thresh)
    else $error("threshold flag wrong");
  c_sync: cover property (@(posedge ref_clk) disable iff (clr) $rose(sync_on));
  c_conv: cover property (@(posedge ref_clk) disable iff (clr) $rose(result_valid));
  c_boost: cover property (@(posedge ref_clk) disable iff (clr)
    probe_node_select == NODE_BOOST && cif.sample);
endmodule

// ---- rtl/fun_light_output_pkg.sv ----
// package: register map, field layout and timing constants for fun-light and led test
package funlight_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [6:0] OFS_FUN_LIGHT_CURRENT = 7'h0C;
  localparam logic [6:0] OFS_AUDIO_SYNC_CTRL   = 7'h0D;
  localparam logic [6:0] OFS_AUDIO_THRESHOLD   = 7'h0E;
  localparam logic [6:0] OFS_LED_TEST_CTRL     = 7'h12;
  localparam logic [6:0] OFS_CONVERTER_RESULT  = 7'h13;
  localparam logic [6:0] OFS_SOFT_RESET        = 7'h60;
  // ********************************
  // field positions
  // ********************************
  localparam int GAIN_MSB        = 7;
  localparam int GAIN_LSB        = 5;
  localparam int DC_CORNER_BIT   = 4;
  localparam int AGC_BIT         = 3;
  localparam int SYNC_BIT        = 2;
  localparam int SPEED_MSB       = 1;
  localparam int THRESH_MSB      = 3;
  localparam int CONVERT_ON_BIT  = 4;
  localparam int NODE_MSB        = 3;
  localparam int DUTY_MSB        = 5;
  localparam int PULSE_LVL_LSB   = 6;
  // ********************************
  // reset values
  // ********************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  // ********************************
  // mux codes
  // ********************************
  localparam logic [3:0] NODE_LAST_RGB  = 4'hB;
  localparam logic [3:0] NODE_FUN_LIGHT = 4'hC;
  localparam logic [3:0] NODE_BOOST     = 4'hF;
  // ********************************
  // timing
  // ********************************
  localparam int CLK_HZ         = 20_000_000;
  localparam int CONV_PERIOD_NS = 128_000;
  localparam int CONV_CYCLES    = CONV_PERIOD_NS / (1_000_000_000 / CLK_HZ);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } conv_state_t;
endpackage
